/* File: rtl/pwm_timer_pkg.sv */
// Package of constants for the 16-bit fast and phase correct PWM timer
// Behaviour
// - Modes 5,6,7,14,15 count single-slope from zero to TOP, then restart.
// - Fast PWM code 2 sets on match, clears at TOP; code 3 inverse.
// - Fixed TOP 0x00FF/0x01FF/0x03FF for modes 5/6/7; clear after TOP.
// - Mode 14 TOP from capture register, mode 15 from compare A.
// - Fast PWM sets overflow at TOP, plus compare-A or capture flag.
// - Counter matching compare A or B sets that channel's flag.
// - With fixed TOP, compare writes store bits above resolution as zero.
// - Capture TOP is unbuffered; below count, counter wraps through 0xFFFF.
// - Fast PWM loads compare from buffer at TOP with clear and overflow.
// - Pin driven only when direction bit and pin output enable both set.
// - Fast PWM compare zero gives spike; compare TOP gives constant level.
// - Fast PWM code 1 on channel A toggles on match, buffered.
// - Modes 1,2,3,10,11 count dual-slope up to TOP and down.
// - Phase correct TOP fixed, capture, or compare A; hold TOP once.
// - Phase correct code 2 clears on up match, sets on down.
// - Phase correct overflow at zero; TOP flag at buffer load.
// - Phase correct extremes give constant low or high by polarity.
// - Output mode code zero leaves compare output unchanged.
// - Logic on one clock; timer tick is an enable for counting, compare output and flag setting.
package pwm_timer_pkg;
   // APB register byte offsets
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] cmp_a_off = 8'h04;
   localparam logic [7:0] cmp_b_off = 8'h08;
   localparam logic [7:0] cap_off = 8'h0C;
   localparam logic [7:0] count_off = 8'h10;
   localparam logic [7:0] flags_off = 8'h14;
   // Control register field positions
   localparam int mode_lsb = 0;
   localparam int com_a_lsb = 4;
   localparam int com_b_lsb = 6;
   localparam int dir_a_bit = 8;
   localparam int dir_b_bit = 9;
   localparam int oe_a_bit = 10;
   localparam int oe_b_bit = 11;
   localparam int tick_bit = 12;
   // Flag register field positions
   localparam int ovf_bit = 0;
   localparam int cmpa_flag_bit = 1;
   localparam int cmpb_flag_bit = 2;
   localparam int cap_flag_bit = 3;
   // Fixed TOP values
   localparam logic [15:0] top8 = 16'h00FF;
   localparam logic [15:0] top9 = 16'h01FF;
   localparam logic [15:0] top10 = 16'h03FF;
   localparam logic [15:0] max_count = 16'hFFFF;
   localparam logic [15:0] reset_word = 16'h0000;
   // Waveform modes handled by this block
   localparam logic [3:0] pc8 = 4'h1;
   localparam logic [3:0] pc9 = 4'h2;
   localparam logic [3:0] pc10 = 4'h3;
   localparam logic [3:0] fp8 = 4'h5;
   localparam logic [3:0] fp9 = 4'h6;
   localparam logic [3:0] fp10 = 4'h7;
   localparam logic [3:0] pc_cap = 4'hA;
   localparam logic [3:0] pc_cmp = 4'hB;
   localparam logic [3:0] fp_cap = 4'hE;
   localparam logic [3:0] fp_cmp = 4'hF;
   // Output mode codes
   localparam logic [1:0] com_off = 2'h0;
   localparam logic [1:0] com_toggle = 2'h1;
   localparam logic [1:0] com_noninv = 2'h2;
   localparam logic [1:0] com_inv = 2'h3;
endpackage : pwm_timer_pkg

/* File: rtl/compare_if.sv */
// Interface carrying one compare channel's inputs and outputs
`timescale 1ns/1ps
`default_nettype none
interface compare_if;
   logic [15:0] active;
   logic [1:0] mode;
   logic toggle_ok;
   logic match;
   logic state;
   modport unit (input active, input mode, input toggle_ok, output match, output state);
   modport ctrl (output active, output mode, output toggle_ok, input match, input state);
endinterface : compare_if
`default_nettype wire

/* File: rtl/compare_unit.sv */
// One compare channel: match detect and output state update
`timescale 1ns/1ps
`default_nettype none
module compare_unit (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic fast,
   input wire logic pwm,
   input wire logic at_top,
   input wire logic count_up,
   input wire logic [15:0] count,
   compare_if.unit cu
);
   logic hit;
   logic next_state;
   logic set_val;
   logic up_match;
   // match only while counter equals active compare value
   assign hit = pwm && (count == cu.active);
   assign cu.match = tick && hit;
   // Level written on a fast match: high for code 2, low for code 3
   assign set_val = (cu.mode == pwm_timer_pkg::com_noninv);
   // Dual-slope direction of a match; TOP counts as down and BOTTOM as up,
   // otherwise a compare at either end would flip the steady level
   assign up_match = (count_up || count == pwm_timer_pkg::reset_word) && !at_top;
   // Output state decision; match wins over TOP restore so compare==TOP is steady
   always_comb
   begin
      next_state = cu.state;
      if (tick && pwm)
      begin
         // code zero leaves the state untouched
         if (cu.mode == pwm_timer_pkg::com_off)
            next_state = cu.state;
         // toggle only where allowed for this channel
         else if (cu.mode == pwm_timer_pkg::com_toggle)
         begin
            if (hit && cu.toggle_ok)
               next_state = ~cu.state;
         end
         else if (fast)
         begin
            // set on match, restore at TOP; match first gives steady level
            if (hit)
               next_state = set_val;
            else if (at_top)
               next_state = (cu.mode == pwm_timer_pkg::com_inv);
         end
         else if (hit)
         begin
            // clear on up match, set on down match; inverted for code 3
            next_state = (~up_match) ^ (cu.mode == pwm_timer_pkg::com_inv);
         end
      end
   end
   // state register not touched by mode changes
   always_ff @(posedge clk)
   begin
      if (rst)
         cu.state <= 1'b0;
      else
         cu.state <= next_state;
   end
endmodule : compare_unit
`default_nettype wire

/* File: rtl/pwm_timer.sv */
// Top of the 16-bit fast and phase correct PWM timer with APB slave
`timescale 1ns/1ps
`default_nettype none
module pwm_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic timer_tick,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic pin_a_out,
   output logic pin_a_oe,
   output logic pin_b_out,
   output logic pin_b_oe
);
   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   logic [15:0] ctrl;
   logic [15:0] buf_a;
   logic [15:0] buf_b;
   logic [15:0] act_a;
   logic [15:0] act_b;
   logic [15:0] capture_top_register;
   logic [15:0] counter_value;
   logic count_up;
   logic overflow_flag;
   logic cmpa_flag;
   logic cmpb_flag;
   logic capture_match_flag;
   logic tick_sync1;
   logic tick_sync2;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire [3:0] waveform_mode_select = ctrl[pwm_timer_pkg::mode_lsb +: 4];
   wire [1:0] channel_a_output_mode = ctrl[pwm_timer_pkg::com_a_lsb +: 2];
   wire [1:0] channel_b_output_mode = ctrl[pwm_timer_pkg::com_b_lsb +: 2];
   wire soft_tick = ctrl[pwm_timer_pkg::tick_bit];
   wire wr = psel && penable && pwrite;
   wire rd_ok = (paddr <= pwm_timer_pkg::flags_off) && (paddr[1:0] == 2'h0);
   wire wr_ctrl = wr && paddr == pwm_timer_pkg::ctrl_off;
   wire wr_a = wr && paddr == pwm_timer_pkg::cmp_a_off;
   wire wr_b = wr && paddr == pwm_timer_pkg::cmp_b_off;
   wire wr_cap = wr && paddr == pwm_timer_pkg::cap_off;
   wire wr_cnt = wr && paddr == pwm_timer_pkg::count_off;
   wire wr_flags = wr && paddr == pwm_timer_pkg::flags_off;
   wire fast = waveform_mode_select == pwm_timer_pkg::fp8 ||
      waveform_mode_select == pwm_timer_pkg::fp9 ||
      waveform_mode_select == pwm_timer_pkg::fp10 ||
      waveform_mode_select == pwm_timer_pkg::fp_cap ||
      waveform_mode_select == pwm_timer_pkg::fp_cmp;
   wire phase = waveform_mode_select == pwm_timer_pkg::pc8 ||
      waveform_mode_select == pwm_timer_pkg::pc9 ||
      waveform_mode_select == pwm_timer_pkg::pc10 ||
      waveform_mode_select == pwm_timer_pkg::pc_cap ||
      waveform_mode_select == pwm_timer_pkg::pc_cmp;
   wire pwm = fast || phase;
   wire top_cap = waveform_mode_select == pwm_timer_pkg::fp_cap ||
      waveform_mode_select == pwm_timer_pkg::pc_cap;
   wire top_cmp = waveform_mode_select == pwm_timer_pkg::fp_cmp ||
      waveform_mode_select == pwm_timer_pkg::pc_cmp;
   wire [1:0] res_sel = waveform_mode_select[1:0];
   wire fixed_top = pwm && !top_cap && !top_cmp;
   // Timer tick: pin-side enable synchronised, or software free-run bit
   // one clock, tick acts only as an enable
   wire tick = tick_sync2 || soft_tick;

   // TOP selection; capture is live, compare A is the active copy
   wire [15:0] top = top_cap ? capture_top_register :
      top_cmp ? act_a :
      (res_sel == 2'h1) ? pwm_timer_pkg::top8 :
      (res_sel == 2'h2) ? pwm_timer_pkg::top9 : pwm_timer_pkg::top10;
   // mask written compare data to the fixed resolution
   wire [15:0] wmask = fixed_top ? top : pwm_timer_pkg::max_count;
   wire [15:0] wdata_cmp = pwdata[15:0] & wmask;
   // exact equality, so a TOP below the count is passed by until wrap
   wire at_top = pwm && counter_value == top;
   wire at_bottom = counter_value == pwm_timer_pkg::reset_word;
   // Buffer load point: TOP in both PWM modes
   wire load = tick && at_top;

   // ----------------------------------------------------------------
   // Compare channels
   // ----------------------------------------------------------------
   compare_if ch_a ();
   compare_if ch_b ();
   assign ch_a.active = act_a;
   assign ch_a.mode = channel_a_output_mode;
   assign ch_a.toggle_ok = fast;
   assign ch_b.active = act_b;
   assign ch_b.mode = channel_b_output_mode;
   assign ch_b.toggle_ok = 1'b0;

   compare_unit unit_a (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .fast(fast),
      .pwm(pwm),
      .at_top(at_top),
      .count_up(count_up),
      .count(counter_value),
      .cu(ch_a)
   );
   compare_unit unit_b (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .fast(fast),
      .pwm(pwm),
      .at_top(at_top),
      .count_up(count_up),
      .count(counter_value),
      .cu(ch_b)
   );

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   logic [15:0] next_count;
   logic next_up;
   // Next count; mode change keeps count and continues from it
   always_comb
   begin
      next_count = counter_value;
      next_up = count_up;
      if (wr_cnt)
         next_count = pwdata[15:0];
      else if (tick && pwm)
      begin
         if (fast)
         begin
            next_up = 1'b1;
            // clear on the tick after TOP was reached
            if (at_top)
               next_count = pwm_timer_pkg::reset_word;
            else
               next_count = 16'(counter_value + 16'h0001);
         end
         // hold TOP one tick, then reverse
         else if (at_top)
         begin
            next_up = 1'b0;
            next_count = 16'(counter_value - 16'h0001);
         end
         else if (at_bottom && !count_up)
         begin
            next_up = 1'b1;
            next_count = 16'h0001;
         end
         else if (count_up)
            next_count = 16'(counter_value + 16'h0001);
         else
            next_count = 16'(counter_value - 16'h0001);
      end
   end

   // Counter and direction registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         counter_value <= pwm_timer_pkg::reset_word;
         count_up <= 1'b1;
      end
      else
      begin
         counter_value <= next_count;
         count_up <= next_up;
      end
   end

   // ----------------------------------------------------------------
   // Control, buffers and active compare values
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl <= pwm_timer_pkg::reset_word;
         buf_a <= pwm_timer_pkg::reset_word;
         buf_b <= pwm_timer_pkg::reset_word;
         act_a <= pwm_timer_pkg::reset_word;
         act_b <= pwm_timer_pkg::reset_word;
         capture_top_register <= pwm_timer_pkg::reset_word;
      end
      else
      begin
         if (wr_ctrl)
            ctrl <= pwdata[15:0];
         if (wr_a)
            buf_a <= wdata_cmp;
         if (wr_b)
            buf_b <= wdata_cmp;
         // capture TOP takes effect at once
         if (wr_cap)
            capture_top_register <= pwdata[15:0];
         // active compare loaded from buffer at TOP
         if (load)
         begin
            act_a <= buf_a;
            act_b <= buf_b;
         end
      end
   end

   // ----------------------------------------------------------------
   // Flags: hardware set wins over write-one-to-clear
   // ----------------------------------------------------------------
   // overflow at TOP in fast PWM; at zero in phase correct
   wire set_ovf = tick && ((fast && at_top) || (phase && at_bottom && !count_up));
   // TOP-defining register flag at the load point
   wire set_cmpa = ch_a.match || (load && top_cmp);
   wire set_cap = load && top_cap;
   wire set_cmpb = ch_b.match;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         overflow_flag <= 1'b0;
         cmpa_flag <= 1'b0;
         cmpb_flag <= 1'b0;
         capture_match_flag <= 1'b0;
      end
      else
      begin
         overflow_flag <= set_ovf || (overflow_flag && !(wr_flags && pwdata[pwm_timer_pkg::ovf_bit]));
         cmpa_flag <= set_cmpa ||
            (cmpa_flag && !(wr_flags && pwdata[pwm_timer_pkg::cmpa_flag_bit]));
         cmpb_flag <= set_cmpb ||
            (cmpb_flag && !(wr_flags && pwdata[pwm_timer_pkg::cmpb_flag_bit]));
         capture_match_flag <= set_cap ||
            (capture_match_flag && !(wr_flags && pwdata[pwm_timer_pkg::cap_flag_bit]));
      end
   end

   // Two-stage synchroniser for the external tick pin
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tick_sync1 <= 1'b0;
         tick_sync2 <= 1'b0;
      end
      else
      begin
         tick_sync1 <= timer_tick;
         tick_sync2 <= tick_sync1;
      end
   end

   // ----------------------------------------------------------------
   // APB read path; zero-wait, unmapped offsets answer pslverr
   // ----------------------------------------------------------------
   wire [31:0] rd_mux = (paddr == pwm_timer_pkg::ctrl_off) ? {16'h0000, ctrl} :
      (paddr == pwm_timer_pkg::cmp_a_off) ? {16'h0000, buf_a} :
      (paddr == pwm_timer_pkg::cmp_b_off) ? {16'h0000, buf_b} :
      (paddr == pwm_timer_pkg::cap_off) ? {16'h0000, capture_top_register} :
      (paddr == pwm_timer_pkg::count_off) ? {16'h0000, counter_value} :
      (paddr == pwm_timer_pkg::flags_off) ? {28'h0000000, capture_match_flag, cmpb_flag,
      cmpa_flag, overflow_flag} : 32'h00000000;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !rd_ok;
   // Read data registered in the setup phase, valid in the access phase
   always_ff @(posedge clk)
   begin
      if (rst)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_mux;
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   // drive only with direction bit, pin enable and a nonzero mode
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_a_out <= 1'b0;
         pin_b_out <= 1'b0;
         pin_a_oe <= 1'b0;
         pin_b_oe <= 1'b0;
      end
      else
      begin
         pin_a_out <= ch_a.state;
         pin_b_out <= ch_b.state;
         pin_a_oe <= ctrl[pwm_timer_pkg::dir_a_bit] && ctrl[pwm_timer_pkg::oe_a_bit] &&
            channel_a_output_mode != pwm_timer_pkg::com_off;
         pin_b_oe <= ctrl[pwm_timer_pkg::dir_b_bit] && ctrl[pwm_timer_pkg::oe_b_bit] &&
            channel_b_output_mode != pwm_timer_pkg::com_off;
      end
   end
endmodule : pwm_timer
`default_nettype wire

/* File: dv/pin_load.sv */
// Model of the external load seen on one compare output pin
`timescale 1ns/1ps
`default_nettype none
module pin_load (
   input wire logic clk,
   input wire logic drive,
   input wire logic oe,
   output logic pad
);
   logic last = 1'b0;
   // pad follows only when driven
   // An undriven pad flips every cycle so that a stale level never passes for a driven one
   assign pad = oe ? drive : ~last;
   // Plain always so the start value above is allowed
   always @(posedge clk)
   begin
      last <= pad;
   end
endmodule : pin_load
`default_nettype wire

/* File: dv/pwm_timer_checker.sv */
// Port-level assertions for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic timer_tick,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pin_a_out,
   input wire logic pin_a_oe,
   input wire logic pin_b_out,
   input wire logic pin_b_oe
);
   // ----------
   // Helper logic
   // ----------
   logic [12:0] ctrl_q;
   logic [2:0] idle_cnt;
   wire logic acc = psel & penable;
   wire logic bad_addr = (paddr > 8'h14) | (paddr[1:0] != 2'h0);
   wire logic pwm_m = ctrl_q[3:0] inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB,
      4'hE, 4'hF};
   wire logic quiet_a = (ctrl_q[5:4] == 2'h0) | ~pwm_m;
   wire logic quiet_b = (ctrl_q[7:6] == 2'h0) | ~pwm_m;
   wire logic oe_a_exp = ctrl_q[8] & ctrl_q[10] & (ctrl_q[5:4] != 2'h0);
   wire logic oe_b_exp = ctrl_q[9] & ctrl_q[11] & (ctrl_q[7:6] != 2'h0);
   // Shadow of the control word, taken when the access completes
   always_ff @(posedge clk)
   begin
      if (rst)
         ctrl_q <= 13'h0000;
      else if (acc && pwrite && pready && paddr == 8'h00)
         ctrl_q <= pwdata[12:0];
   end
   // Saturating count of cycles with no tick source; the pin path needs several cycles to settle
   always_ff @(posedge clk)
   begin
      if (rst || timer_tick || ctrl_q[12])
         idle_cnt <= 3'h0;
      else if (idle_cnt != 3'h7)
         idle_cnt <= idle_cnt + 3'h1;
   end
   // ----------
   // Assertions
   // ----------
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence acc_s;
      psel && penable;
   endsequence
   chk_ready_access:
      assert property (acc_s |-> pready)
      else $error("pready low in access phase");
   chk_err_map:
      assert property (acc_s |-> pslverr == bad_addr)
      else $error("pslverr does not match address map");
   chk_err_quiet:
      assert property (!acc |-> !pslverr)
      else $error("pslverr outside access phase");
   chk_oe_a_follow:
      assert property (!$past(rst) |-> pin_a_oe == $past(oe_a_exp))
      else $error("pin a enable wrong");
   chk_oe_b_follow:
      assert property (!$past(rst) |-> pin_b_oe == $past(oe_b_exp))
      else $error("pin b enable wrong");
   chk_hold_a_off:
      assert property (!$past(rst) && $past(quiet_a) && $past(quiet_a, 2) |-> $stable(pin_a_out))
      else $error("pin a changed with no action");
   chk_hold_b_off:
      assert property (!$past(rst) && $past(quiet_b) && $past(quiet_b, 2) |-> $stable(pin_b_out))
      else $error("pin b changed with no action");
   chk_idle_hold:
      assert property (idle_cnt == 3'h7 |-> $stable(pin_a_out) && $stable(pin_b_out))
      else $error("pin changed without tick");
   chk_reset_pins:
      assert property ($fell(rst) |-> !pin_a_out && !pin_b_out && !pin_a_oe && !pin_b_oe)
      else $error("pins not cleared by reset");
endmodule : pwm_timer_checker
bind pwm_timer pwm_timer_checker chk_i (.clk, .rst, .timer_tick, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_a_out, .pin_a_oe, .pin_b_out,
   .pin_b_oe);
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the PWM timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic timer_tick = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata, rd_data;
   logic pready, pslverr, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pad_a, pad_b, rd_err;
   int n_mismatch = 0;
   int cmp_count = 0;
   int seed = 32'hFDD7;
   int cnt_m = 0;
   int dn_m = 0;
   // Byte strobes are not decoded, so full words only
   pwm_timer dut (.clk, .rst, .timer_tick, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe);
   pin_load load_a (.clk, .drive(pin_a_out), .oe(pin_a_oe), .pad(pad_a));
   pin_load load_b (.clk, .drive(pin_b_out), .oe(pin_b_oe), .pad(pad_b));
   // 250 MHz clock
   initial
   begin
      forever #2 clk = ~clk;
   end
   // ----------
   // Tasks
   // ----------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   task automatic check(input string nm, input logic [31:0] want, input logic [31:0] got);
      cmp_count++;
      if (got !== want)
      begin
         $display("mismatch %s expected %h seen %h", nm, want, got);
         n_mismatch++;
      end
   endtask : check
   // One APB transfer; the wait for pready is bounded
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         n_mismatch++;
         summarize();
      end
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] want);
      apb(1'b0, a, 32'h0);
      check(nm, want, rd_data);
   endtask : rchk
   // Single tick through the pin, then the counter is compared with the model
   task automatic step(input int fast, input int top);
      @(posedge clk);
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
      repeat (4) @(posedge clk);
      if (fast)
         cnt_m = (cnt_m == top) ? 0 : (cnt_m + 1) % 65536;
      else
      begin
         if (cnt_m == top)
            dn_m = 1;
         else if (cnt_m == 0)
            dn_m = 0;
         cnt_m = dn_m ? cnt_m - 1 : cnt_m + 1;
      end
      rchk("count", pwm_timer_pkg::count_off, cnt_m);
   endtask : step
   // High cycles over two PWM periods for one channel; -1 when the level is not defined
   function automatic int high(input int code, c, top, fast);
      int per;
      int h;
      per = fast ? top + 1 : 2 * top;
      h = fast ? ((c > top) ? 0 : (c == top) ? per : top - c) : 2 * c;
      if (code == 3)
         h = per - h;
      if (code == 1)
         h = per / 2;
      return (code == 0) ? -1 : 2 * h;
   endfunction : high
   task automatic duty(input logic [3:0] md, input int ca, cb, va, vb, top, fast);
      logic [31:0] c;
      int w;
      int ha;
      int hb;
      int ea;
      c = {20'h0, 4'hF, cb[1:0], ca[1:0], md};
      wr(pwm_timer_pkg::ctrl_off, c);
      wr(pwm_timer_pkg::count_off, 32'h0);
      wr(pwm_timer_pkg::cap_off, top);
      wr(pwm_timer_pkg::cmp_a_off, va);
      wr(pwm_timer_pkg::cmp_b_off, vb);
      wr(pwm_timer_pkg::ctrl_off, c | 32'h1000);
      w = fast ? 2 * (top + 1) : 4 * top;
      ha = 0;
      hb = 0;
      repeat (3 * w) @(posedge clk);
      // Pads sampled away from the edge that launches them
      repeat (w)
      begin
         @(negedge clk);
         ha += (pad_a === 1'b1);
         hb += (pad_b === 1'b1);
      end
      ea = high(ca, va, top, fast);
      if (ea >= 0)
         check("high_a", ea, ha);
      check("high_b", high(cb, vb, top, fast), hb);
   endtask : duty
   // ----------
   // Main sequence
   // ----------
   initial
   begin
      logic [31:0] v;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a <= 20; a += 4)
         rchk("reset", a[7:0], 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      check("err_unmapped", 32'h1, {31'h0, rd_err});
      apb(1'b1, 8'h06, 32'hFFFF);
      check("err_unaligned", 32'h1, {31'h0, rd_err});
      // Fixed TOP modes mask compare writes; register TOP modes keep all 16 bits
      for (int i = 0; i < 6; i++)
      begin
         v = $random(seed);
         wr(pwm_timer_pkg::ctrl_off, (i < 3) ? 5 + i : i - 2);
         wr(pwm_timer_pkg::cmp_a_off, v);
         wr(pwm_timer_pkg::cmp_b_off, ~v);
         rchk("cmp_a", pwm_timer_pkg::cmp_a_off, v & ((32'h100 << (i % 3)) - 1));
         rchk("cmp_b", pwm_timer_pkg::cmp_b_off, ~v & ((32'h100 << (i % 3)) - 1));
      end
      wr(pwm_timer_pkg::ctrl_off, pwm_timer_pkg::pc_cap);
      wr(pwm_timer_pkg::cmp_a_off, v);
      rchk("cmp_a_full", pwm_timer_pkg::cmp_a_off, {16'h0, v[15:0]});
      // Stepped counting: dual slope, mode switch, wrap past a low TOP
      // smallest legal TOP
      wr(pwm_timer_pkg::cap_off, 32'h3);
      repeat (8) step(0, 3);
      wr(pwm_timer_pkg::ctrl_off, pwm_timer_pkg::fp_cap);
      repeat (4) step(1, 3);
      wr(pwm_timer_pkg::count_off, 32'hFFFE);
      cnt_m = 32'hFFFE;
      repeat (3) step(1, 3);
      // Pin enable needs both direction and enable bits
      for (int i = 0; i < 4; i++)
      begin
         wr(pwm_timer_pkg::ctrl_off, 32'h23 | ((i & 1) << 8) | ((i & 2) << 9));
         repeat (3) @(posedge clk);
         check("pin_a_oe", (i == 3), pin_a_oe);
      end
      duty(pwm_timer_pkg::fp_cap, 2, 3, 3, 7, 7, 1);
      duty(pwm_timer_pkg::fp_cap, 3, 2, 0, 0, 7, 1);
      duty(pwm_timer_pkg::fp_cap, 1, 2, 2, 4, 7, 1);
      duty(pwm_timer_pkg::pc_cap, 2, 3, 3, 7, 7, 0);
      duty(pwm_timer_pkg::pc_cap, 2, 3, 0, 2, 7, 0);
      duty(pwm_timer_pkg::fp_cmp, 0, 2, 5, 2, 5, 1);
      duty(pwm_timer_pkg::pc_cmp, 0, 3, 9, 4, 9, 0);
      duty(pwm_timer_pkg::pc8, 2, 3, 255, 100, 255, 0);
      duty(pwm_timer_pkg::fp9, 3, 2, 511, 500, 511, 1);
      duty(pwm_timer_pkg::fp_cap, 2, 2, 3, 9, 7, 1);
      wr(pwm_timer_pkg::flags_off, 32'hF);
      repeat (20) @(posedge clk);
      rchk("flags", pwm_timer_pkg::flags_off, 32'hB);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
